// ### hw/csr_pkg.sv
// Constants, codes and types shared by the charger status readout block
package csr_pkg;

  // ==========================================================================
  // Register offsets on the register port
  localparam logic [7:0] ADDR_SILICON_REVISION = 8'h00;
  localparam logic [7:0] ADDR_THERMAL_CHARGE_STATUS = 8'h01;
  localparam logic [7:0] ADDR_INPUT_CHARGER_FLAGS = 8'h02;

  // ==========================================================================
  // Reset values
  // Revision value is arbitrary; the real one is set per tape-out
  localparam logic [7:0] HW_REV_DEFAULT = 8'h01;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [5:0] SYNC_RESET = 6'h00;
  localparam logic [2:0] ZONE_RESET = 3'h0;
  localparam logic [2:0] CHG_RESET = 3'h0;

  // ==========================================================================
  // Field positions
  localparam int ZONE_LSB = 3;
  localparam int ZONE_MSB = 5;
  localparam int CHG_LSB = 0;
  localparam int CHG_MSB = 2;
  localparam int FLAG_INPUT_CURRENT_LIMIT_FLAG = 5;
  localparam int FLAG_OVP = 4;
  localparam int FLAG_VALID = 3;
  localparam int FLAG_TSD = 2;
  localparam int FLAG_TREG = 1;
  localparam int FLAG_TMO = 0;
  localparam int UNUSED_MSB = 7;
  localparam int UNUSED_LSB = 6;

  // Thermistor comparator positions, one bit per threshold exceeded
  localparam int CMP_DIS = 4;
  localparam int CMP_COLD = 3;
  localparam int CMP_COOL = 2;
  localparam int CMP_WARM = 1;
  localparam int CMP_HOT = 0;

  // Synchroniser depth, settle cycles and the thermistor enable off value
  localparam int SYNC_STAGES = 2;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  localparam logic [1:0] THM_EN_OFF = 2'h0;

  // ==========================================================================
  // Field encodings
  typedef logic [2:0] csr_code_t;
  localparam csr_code_t ZONE_COLD = 3'h0;
  localparam csr_code_t ZONE_COOL = 3'h1;
  localparam csr_code_t ZONE_ROOM = 3'h2;
  localparam csr_code_t ZONE_WARM = 3'h3;
  localparam csr_code_t ZONE_HOT = 3'h4;
  localparam csr_code_t ZONE_NO_THM = 3'h5;
  localparam csr_code_t ZONE_MON_OFF = 3'h6;
  localparam csr_code_t ZONE_HRV_OFF = 3'h7;

  localparam csr_code_t CHG_CODE_OFF = 3'h0;
  localparam csr_code_t CHG_CODE_TEMP_SUSP = 3'h1;
  localparam csr_code_t CHG_CODE_PRECHG = 3'h2;
  localparam csr_code_t CHG_CODE_FAST_CC = 3'h3;
  localparam csr_code_t CHG_CODE_FAST_CV = 3'h4;
  localparam csr_code_t CHG_CODE_MAINTAIN = 3'h5;
  localparam csr_code_t CHG_CODE_MAINT_DONE = 3'h6;
  localparam csr_code_t CHG_CODE_FAULT = 3'h7;

  // One-hot state vector presented by the charger controller
  typedef enum logic [7:0] {
    CHG_ST_OFF = 8'h01,
    CHG_ST_TEMP_SUSP = 8'h02,
    CHG_ST_PRECHG = 8'h04,
    CHG_ST_FAST_CC = 8'h08,
    CHG_ST_FAST_CV = 8'h10,
    CHG_ST_MAINTAIN = 8'h20,
    CHG_ST_MAINT_DONE = 8'h40,
    CHG_ST_FAULT = 8'h80
  } csr_chg_state_t;

endpackage

// ### hw/csr_status_top.sv
// Read-only revision, thermistor, charger state and input flag registers
//
// Contract
// RULE1 - Offset zero reads a fixed 8-bit hardware revision code in bits 7:0.
// RULE2 - Zone field bits 5:3 report cold, cool, room, warm, hot as 000 to 100.
// RULE3 - Zone field reads 101 when thermistor voltage exceeds the disconnect threshold.
// RULE4 - Zone reads 110 when the active monitor path has both enables off.
// RULE5 - Zone reads 111 without input, charger enable on, harvester enable off.
// RULE6 - Charger field bits 2:0 read 000 off, 001 temperature suspend, 010 precharge.
// RULE7 - Charger field reads 011 CC, 100 CV, 101 maintain, 110 done, 111 fault.
// RULE8 - Flags bit 5 shows input current limit active.
// RULE9 - Flags bit 4 shows input overvoltage detected.
// RULE10 - Flags bit 3 shows input present and inside its valid range.
// RULE11 - Flags bit 2 shows charger disabled by the temperature profile.
// RULE12 - Flags bit 1 shows temperature profile reducing charge current or voltage.
// RULE13 - Flags bit 0 shows charger time-out reached.
// RULE14 - Writes are ignored; bits 7 and 6 of both status registers read zero.
`timescale 1ns/100ps

module csr_status_top #(
  parameter logic [7:0] P_HW_REV = csr_pkg::HW_REV_DEFAULT
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Register port from the serial interface engine
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd_en,
  input wire logic i_reg_wr_en,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rd_valid,
  // Thermistor comparators from the analog monitor
  input wire logic i_thm_above_disconnect,
  input wire logic i_thm_above_cold,
  input wire logic i_thm_above_cool,
  input wire logic i_thm_above_warm,
  input wire logic i_thm_above_hot,
  // Thermistor enables from configuration registers
  input wire logic [1:0] i_charger_thermistor_enable,
  input wire logic [1:0] i_harvester_thermistor_enable,
  // Charger input protection status from the analog front end
  input wire logic i_charger_input_supply_present,
  input wire logic i_input_current_limit,
  input wire logic i_input_overvoltage,
  input wire logic i_input_valid,
  // Charger controller status
  input wire logic i_temp_profile_shutdown,
  input wire logic i_temp_profile_reduction,
  input wire logic i_charge_timeout,
  input wire logic [7:0] i_charger_state_onehot
);

  // ==========================================================================
  // Functions

  // Malformed one-hot vectors read as a fault so software never sees a benign code
  function automatic csr_pkg::csr_code_t chg_code(input logic [7:0] st);
    csr_pkg::csr_code_t code;
    code = csr_pkg::CHG_CODE_FAULT;
    unique case (st)
      csr_pkg::CHG_ST_OFF: code = csr_pkg::CHG_CODE_OFF; // RULE6
      csr_pkg::CHG_ST_TEMP_SUSP: code = csr_pkg::CHG_CODE_TEMP_SUSP; // RULE6
      csr_pkg::CHG_ST_PRECHG: code = csr_pkg::CHG_CODE_PRECHG; // RULE6
      csr_pkg::CHG_ST_FAST_CC: code = csr_pkg::CHG_CODE_FAST_CC; // RULE7
      csr_pkg::CHG_ST_FAST_CV: code = csr_pkg::CHG_CODE_FAST_CV; // RULE7
      csr_pkg::CHG_ST_MAINTAIN: code = csr_pkg::CHG_CODE_MAINTAIN; // RULE7
      csr_pkg::CHG_ST_MAINT_DONE: code = csr_pkg::CHG_CODE_MAINT_DONE; // RULE7
      csr_pkg::CHG_ST_FAULT: code = csr_pkg::CHG_CODE_FAULT; // RULE7
      default: code = csr_pkg::CHG_CODE_FAULT; // RULE7
    endcase
    return code;
  endfunction

  // ==========================================================================
  // Declarations
  logic [5:0] flag_s1;
  logic [5:0] flag_s2;
  logic [5:0] thm_s1;
  logic [5:0] thm_s2;
  csr_pkg::csr_code_t chg_state;
  logic [7:0] thermal_charge_status;
  logic [7:0] input_charger_flags;
  logic [7:0] next_rdata;
  logic [1:0] settle_cnt;
  logic settled;

  csr_thm_if thm ();

  // ==========================================================================
  // Input synchronisers
  // Analog comparators toggle with no relation to the clock, so every pin takes
  // two flops; only the second stage is read by anything else.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_s1 <= csr_pkg::SYNC_RESET;
      flag_s2 <= csr_pkg::SYNC_RESET;
      thm_s1 <= csr_pkg::SYNC_RESET;
      thm_s2 <= csr_pkg::SYNC_RESET;
    end else begin
      flag_s1 <= {i_input_current_limit, i_input_overvoltage, i_input_valid,
                  i_temp_profile_shutdown, i_temp_profile_reduction, i_charge_timeout};
      flag_s2 <= flag_s1;
      thm_s1 <= {i_charger_input_supply_present, i_thm_above_disconnect, i_thm_above_cold,
                 i_thm_above_cool, i_thm_above_warm, i_thm_above_hot};
      thm_s2 <= thm_s1;
    end
  end

  // ==========================================================================
  // Thermistor zone encoder
  // Enables come from registers on this clock and need no synchroniser
  assign thm.above = thm_s2[4:0];
  assign thm.charger_input_supply_present = thm_s2[5];
  assign thm.chg_thm_en = i_charger_thermistor_enable;
  assign thm.hrv_thm_en = i_harvester_thermistor_enable;

  csr_thm_zone u_thm_zone (
    .i_sys_clk (i_sys_clk),
    .i_rst (i_rst),
    .thm (thm.enc)
  );

  // ==========================================================================
  // Charger state capture
  // The controller shares this clock, so its state is registered directly
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      chg_state <= csr_pkg::CHG_RESET;
    end else begin
      chg_state <= chg_code(i_charger_state_onehot); // RULE6 RULE7
    end
  end

  // Zone and charger fields; bits above them are tied low
  always_comb begin
    thermal_charge_status = csr_pkg::STATUS_RESET; // RULE14
    thermal_charge_status[csr_pkg::ZONE_MSB:csr_pkg::ZONE_LSB] = thm.zone; // RULE2
    thermal_charge_status[csr_pkg::CHG_MSB:csr_pkg::CHG_LSB] = chg_state; // RULE6
  end

  // ==========================================================================
  // Input and charger flags
  // Flags are reported raw; their validity depends on the input flags and the
  // charger enable, which software must check before trusting them.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      input_charger_flags <= csr_pkg::STATUS_RESET;
    end else begin
      input_charger_flags[csr_pkg::UNUSED_MSB:csr_pkg::UNUSED_LSB] <= 2'h0; // RULE14
      input_charger_flags[csr_pkg::FLAG_INPUT_CURRENT_LIMIT_FLAG] <= flag_s2[csr_pkg::FLAG_INPUT_CURRENT_LIMIT_FLAG]; // RULE8
      input_charger_flags[csr_pkg::FLAG_OVP] <= flag_s2[csr_pkg::FLAG_OVP]; // RULE9
      input_charger_flags[csr_pkg::FLAG_VALID] <= flag_s2[csr_pkg::FLAG_VALID]; // RULE10
      input_charger_flags[csr_pkg::FLAG_TSD] <= flag_s2[csr_pkg::FLAG_TSD]; // RULE11
      input_charger_flags[csr_pkg::FLAG_TREG] <= flag_s2[csr_pkg::FLAG_TREG]; // RULE12
      input_charger_flags[csr_pkg::FLAG_TMO] <= flag_s2[csr_pkg::FLAG_TMO]; // RULE13
    end
  end

  // ==========================================================================
  // Register read port
  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (i_reg_addr)
      csr_pkg::ADDR_SILICON_REVISION: next_rdata = P_HW_REV; // RULE1
      csr_pkg::ADDR_THERMAL_CHARGE_STATUS: next_rdata = thermal_charge_status;
      csr_pkg::ADDR_INPUT_CHARGER_FLAGS: next_rdata = input_charger_flags;
      default: next_rdata = csr_pkg::RDATA_RESET;
    endcase
  end

  // Read data holds until the next read; the write strobe and data never reach
  // any storage, so a write has no effect and gets no answer
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= csr_pkg::RDATA_RESET;
      o_reg_rd_valid <= 1'b0;
    end else begin
      o_reg_rd_valid <= i_reg_rd_en; // RULE14
      if (i_reg_rd_en) begin
        o_reg_rdata <= next_rdata;
      end
    end
  end

  // ==========================================================================
  // Check helpers
  // Counts cycles after reset until the synchroniser chain is filled with pin values
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      settle_cnt <= 2'h0;
    end else if (settle_cnt != csr_pkg::SETTLE_CYCLES) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end

  assign settled = (settle_cnt == csr_pkg::SETTLE_CYCLES);

  // ==========================================================================
  // Checks
  a_rev_readback: assert property ( // RULE1
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_rd_en && i_reg_addr == csr_pkg::ADDR_SILICON_REVISION)
      |=> (o_reg_rd_valid && o_reg_rdata == P_HW_REV))
    else $error("Revision read returned wrong value");

  a_zone_readback: assert property ( // RULE2
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_rd_en && i_reg_addr == csr_pkg::ADDR_THERMAL_CHARGE_STATUS)
      |=> (o_reg_rdata[csr_pkg::ZONE_MSB:csr_pkg::ZONE_LSB] == $past(thm.zone)))
    else $error("Zone field not read back");

  a_chg_precharge: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_PRECHG)
      |=> (thermal_charge_status[csr_pkg::CHG_MSB:csr_pkg::CHG_LSB] == csr_pkg::CHG_CODE_PRECHG))
    else $error("Precharge code wrong");

  a_chg_fault_code: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    ($countones(i_charger_state_onehot) != 1 || i_charger_state_onehot == csr_pkg::CHG_ST_FAULT)
      |=> (chg_state == csr_pkg::CHG_CODE_FAULT))
    else $error("Fault code not reported");

  // Remaining charger codes, one check per state of the one-hot vector
  a_chg_off_code: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_OFF) |=> (chg_state == csr_pkg::CHG_CODE_OFF))
    else $error("Charger off code wrong");

  a_chg_temp_susp: assert property ( // RULE6
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_TEMP_SUSP) |=> (chg_state == csr_pkg::CHG_CODE_TEMP_SUSP))
    else $error("Temperature suspend code wrong");

  a_chg_fast_cc: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_FAST_CC) |=> (chg_state == csr_pkg::CHG_CODE_FAST_CC))
    else $error("Constant current code wrong");

  a_chg_fast_cv: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_FAST_CV) |=> (chg_state == csr_pkg::CHG_CODE_FAST_CV))
    else $error("Constant voltage code wrong");

  a_chg_maintain_code: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_MAINTAIN) |=> (chg_state == csr_pkg::CHG_CODE_MAINTAIN))
    else $error("Maintain code wrong");

  a_chg_maint_done: assert property ( // RULE7
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_charger_state_onehot == csr_pkg::CHG_ST_MAINT_DONE) |=> (chg_state == csr_pkg::CHG_CODE_MAINT_DONE))
    else $error("Maintain timer done code wrong");

  a_flag_input_current_limit_flag: assert property ( // RULE8
    @(posedge i_sys_clk) disable iff (i_rst)
    settled |-> (input_charger_flags[csr_pkg::FLAG_INPUT_CURRENT_LIMIT_FLAG] == $past(i_input_current_limit, 3)))
    else $error("Current limit flag mismatch");

  a_flag_ovp: assert property ( // RULE9
    @(posedge i_sys_clk) disable iff (i_rst)
    settled |-> (input_charger_flags[csr_pkg::FLAG_OVP] == $past(i_input_overvoltage, 3)))
    else $error("Overvoltage flag mismatch");

  a_flag_valid: assert property ( // RULE10
    @(posedge i_sys_clk) disable iff (i_rst)
    settled |-> (input_charger_flags[csr_pkg::FLAG_VALID] == $past(i_input_valid, 3)))
    else $error("Input valid flag mismatch");

  a_flag_tsd: assert property ( // RULE11
    @(posedge i_sys_clk) disable iff (i_rst)
    settled |-> (input_charger_flags[csr_pkg::FLAG_TSD] == $past(i_temp_profile_shutdown, 3)))
    else $error("Temperature shutdown flag mismatch");

  a_flag_treg: assert property ( // RULE12
    @(posedge i_sys_clk) disable iff (i_rst)
    settled |-> (input_charger_flags[csr_pkg::FLAG_TREG] == $past(i_temp_profile_reduction, 3)))
    else $error("Temperature reduction flag mismatch");

  a_flag_tmo: assert property ( // RULE13
    @(posedge i_sys_clk) disable iff (i_rst)
    settled |-> (input_charger_flags[csr_pkg::FLAG_TMO] == $past(i_charge_timeout, 3)))
    else $error("Timeout flag mismatch");

  a_upper_bits_zero: assert property ( // RULE14
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_rd_en && (i_reg_addr == csr_pkg::ADDR_THERMAL_CHARGE_STATUS ||
                     i_reg_addr == csr_pkg::ADDR_INPUT_CHARGER_FLAGS))
      |=> (o_reg_rdata[csr_pkg::UNUSED_MSB:csr_pkg::UNUSED_LSB] == 2'h0))
    else $error("Reserved status bits not zero");

  a_write_ignored: assert property ( // RULE14
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_wr_en && !i_reg_rd_en) |=> (!o_reg_rd_valid && $stable(o_reg_rdata)))
    else $error("Write disturbed the read port");

  // Read data only moves on a read, so software can sample it late
  a_rdata_hold: assert property ( // RULE14
    @(posedge i_sys_clk) disable iff (i_rst)
    (!i_reg_rd_en) |=> $stable(o_reg_rdata))
    else $error("Read data changed without a read");

  a_flags_upper_zero: assert property ( // RULE14
    @(posedge i_sys_clk) disable iff (i_rst)
    (input_charger_flags[csr_pkg::UNUSED_MSB:csr_pkg::UNUSED_LSB] == 2'h0))
    else $error("Reserved flag bits not zero");

  a_write_data_dropped: assert property ( // RULE14
    @(posedge i_sys_clk) disable iff (i_rst)
    (i_reg_wr_en && i_reg_wdata != csr_pkg::STATUS_RESET)
      |=> (thermal_charge_status[csr_pkg::UNUSED_MSB:csr_pkg::UNUSED_LSB] == 2'h0))
    else $error("Write data reached a status bit");

endmodule

// ### hw/csr_thm_if.sv
// Thermistor monitor signals passed from the readout top to the zone encoder
`timescale 1ns/100ps

interface csr_thm_if;
  logic [4:0] above;
  logic charger_input_supply_present;
  logic [1:0] chg_thm_en;
  logic [1:0] hrv_thm_en;
  csr_pkg::csr_code_t zone;

  modport drv (output above, output charger_input_supply_present, output chg_thm_en, output hrv_thm_en, input zone);
  modport enc (input above, input charger_input_supply_present, input chg_thm_en, input hrv_thm_en, output zone);
endinterface

// ### hw/csr_thm_zone.sv
// Thermistor zone encoder feeding the zone field of the status register
`timescale 1ns/100ps

module csr_thm_zone (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Synchronised monitor inputs and registered zone
  csr_thm_if.enc thm
);

  // ==========================================================================
  // Zone decision
  csr_pkg::csr_code_t next_zone;

  // Disable cases outrank the comparators, since a disabled monitor has stale comparators
  always_comb begin
    if (thm.charger_input_supply_present && thm.chg_thm_en == csr_pkg::THM_EN_OFF) begin
      next_zone = csr_pkg::ZONE_MON_OFF; // RULE4
    end else if (!thm.charger_input_supply_present && thm.chg_thm_en == csr_pkg::THM_EN_OFF &&
                 thm.hrv_thm_en == csr_pkg::THM_EN_OFF) begin
      next_zone = csr_pkg::ZONE_MON_OFF; // RULE4
    end else if (!thm.charger_input_supply_present && thm.hrv_thm_en == csr_pkg::THM_EN_OFF) begin
      next_zone = csr_pkg::ZONE_HRV_OFF; // RULE5
    end else if (thm.above[csr_pkg::CMP_DIS]) begin
      next_zone = csr_pkg::ZONE_NO_THM; // RULE3
    end else if (thm.above[csr_pkg::CMP_COLD]) begin
      next_zone = csr_pkg::ZONE_COLD; // RULE2
    end else if (thm.above[csr_pkg::CMP_COOL]) begin
      next_zone = csr_pkg::ZONE_COOL; // RULE2
    end else if (thm.above[csr_pkg::CMP_WARM]) begin
      next_zone = csr_pkg::ZONE_ROOM; // RULE2
    end else if (thm.above[csr_pkg::CMP_HOT]) begin
      next_zone = csr_pkg::ZONE_WARM; // RULE2
    end else begin
      next_zone = csr_pkg::ZONE_HOT; // RULE2
    end
  end

  // Zone register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      thm.zone <= csr_pkg::ZONE_RESET;
    end else begin
      thm.zone <= next_zone;
    end
  end

  // ==========================================================================
  // Checks
  a_zone_hot_room: assert property ( // RULE2
    @(posedge i_sys_clk) disable iff (i_rst)
    (thm.charger_input_supply_present && thm.chg_thm_en != csr_pkg::THM_EN_OFF && thm.above == 5'h03)
      |=> (thm.zone == csr_pkg::ZONE_ROOM))
    else $error("Room zone not reported");

  a_zone_no_thm: assert property ( // RULE3
    @(posedge i_sys_clk) disable iff (i_rst)
    (thm.charger_input_supply_present && thm.chg_thm_en != csr_pkg::THM_EN_OFF && thm.above[csr_pkg::CMP_DIS])
      |=> (thm.zone == csr_pkg::ZONE_NO_THM))
    else $error("Missing thermistor not reported");

  a_zone_mon_off: assert property ( // RULE4
    @(posedge i_sys_clk) disable iff (i_rst)
    (thm.chg_thm_en == csr_pkg::THM_EN_OFF &&
     (thm.charger_input_supply_present || thm.hrv_thm_en == csr_pkg::THM_EN_OFF))
      |=> (thm.zone == csr_pkg::ZONE_MON_OFF))
    else $error("Disabled monitor code wrong");

  a_zone_hrv_off: assert property ( // RULE5
    @(posedge i_sys_clk) disable iff (i_rst)
    (!thm.charger_input_supply_present && thm.chg_thm_en != csr_pkg::THM_EN_OFF &&
     thm.hrv_thm_en == csr_pkg::THM_EN_OFF)
      |=> (thm.zone == csr_pkg::ZONE_HRV_OFF))
    else $error("Harvester-off code wrong");

endmodule

// ### verif/csr_status_tb.sv
// Self-checking testbench for the charger status readout registers
`timescale 1ns/100ps

module testbench;
  // ==========================================================================
  // Stimulus and observation signals
  localparam logic [7:0] REV = 8'h5a; // Arbitrary revision value for this run
  logic clk;
  logic rst;
  logic [7:0] addr;
  logic rd_en;
  logic wr_en;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rd_valid;
  logic [4:0] above; // {disconnect, cold, cool, warm, hot}
  logic present;
  logic [1:0] chg_en;
  logic [1:0] hrv_en;
  logic [5:0] flags; // {input_current_limit_flag, ovp, valid, tsd, treg, tmo}
  logic [7:0] state_oh;
  logic [7:0] exp_b[3];
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  // Thermometer codes climbing from hot to no thermistor, with the zone each gives
  logic [4:0] thr[6] = '{5'h00, 5'h01, 5'h03, 5'h07, 5'h0f, 5'h1f};
  csr_pkg::csr_code_t zc[6] = '{csr_pkg::ZONE_HOT, csr_pkg::ZONE_WARM, csr_pkg::ZONE_ROOM,
                                csr_pkg::ZONE_COOL, csr_pkg::ZONE_COLD, csr_pkg::ZONE_NO_THM};
  // Monitor-off cases as {present, charger enable, harvester enable}
  logic [4:0] dm[6] = '{5'h11, 5'h00, 5'h04, 5'h08, 5'h01, 5'h14};
  csr_pkg::csr_code_t dz[6] = '{csr_pkg::ZONE_MON_OFF, csr_pkg::ZONE_MON_OFF, csr_pkg::ZONE_HRV_OFF,
                                csr_pkg::ZONE_HRV_OFF, csr_pkg::ZONE_NO_THM, csr_pkg::ZONE_NO_THM};

  // ==========================================================================
  // Device under test
  csr_status_top #(.P_HW_REV(REV)) u_csr_status_top (
    .i_sys_clk(clk),
    .i_rst(rst),
    .i_reg_addr(addr),
    .i_reg_rd_en(rd_en),
    .i_reg_wr_en(wr_en),
    .i_reg_wdata(wdata),
    .o_reg_rdata(rdata),
    .o_reg_rd_valid(rd_valid),
    .i_thm_above_disconnect(above[4]),
    .i_thm_above_cold(above[3]),
    .i_thm_above_cool(above[2]),
    .i_thm_above_warm(above[1]),
    .i_thm_above_hot(above[0]),
    .i_charger_thermistor_enable(chg_en),
    .i_harvester_thermistor_enable(hrv_en),
    .i_charger_input_supply_present(present),
    .i_input_current_limit(flags[5]),
    .i_input_overvoltage(flags[4]),
    .i_input_valid(flags[3]),
    .i_temp_profile_shutdown(flags[2]),
    .i_temp_profile_reduction(flags[1]),
    .i_charge_timeout(flags[0]),
    .i_charger_state_onehot(state_oh)
  );

  // ==========================================================================
  // Clock, 25 ns period
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // Cycle ceiling; the full sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Status pins pass two sync stages before the register, so give them time to land
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask

  // One read: answer expected in the very next cycle and for that cycle only
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    rd_en = 1'h1;
    addr = a;
    @(negedge clk);
    rd_en = 1'h0;
    check({7'h00, rd_valid}, 8'h01);
    check(rdata, exp);
    @(negedge clk);
    check({7'h00, rd_valid}, 8'h00);
  endtask

  // One write; a read-only bank must not answer it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr_en = 1'h1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'h0;
    @(negedge clk);
    check({7'h00, rd_valid}, 8'h00);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'h1;
    addr = 8'h00;
    rd_en = 1'h0;
    wr_en = 1'h0;
    wdata = 8'h00;
    above = 5'h00;
    present = 1'h1;
    chg_en = 2'h1;
    hrv_en = 2'h1;
    flags = 6'h00;
    state_oh = 8'h01;
    repeat (2) @(negedge clk);
    check(rdata, 8'h00);
    check({7'h00, rd_valid}, 8'h00);
    rst = 1'h0;
    settle();
    // Back-to-back reads over all three registers, one answer per cycle
    exp_b = '{REV, {2'h0, csr_pkg::ZONE_HOT, csr_pkg::CHG_CODE_OFF}, 8'h00};
    @(negedge clk);
    rd_en = 1'h1;
    for (int i = 0; i < 3; i++) begin
      addr = 8'(i);
      @(negedge clk);
      check({7'h00, rd_valid}, 8'h01);
      check(rdata, exp_b[i]);
    end
    rd_en = 1'h0;
    // Every comparator zone, with the monitor enabled on both paths
    for (int i = 0; i < 6; i++) begin
      above = thr[i];
      settle();
      rd(8'h01, {2'h0, zc[i], csr_pkg::CHG_CODE_OFF});
    end
    // Monitor-off cases outrank even a disconnected thermistor
    for (int i = 0; i < 6; i++) begin
      {present, chg_en, hrv_en} = dm[i];
      settle();
      rd(8'h01, {2'h0, dz[i], csr_pkg::CHG_CODE_OFF});
    end
    {present, chg_en, hrv_en} = 5'h15;
    above = 5'h00;
    // Each charger state in turn, then an empty vector that must read as fault
    for (int i = 0; i < 8; i++) begin
      state_oh = 8'(1 << i);
      settle();
      rd(8'h01, {2'h0, csr_pkg::ZONE_HOT, 3'(i)});
    end
    state_oh = 8'h00;
    settle();
    rd(8'h01, {2'h0, csr_pkg::ZONE_HOT, csr_pkg::CHG_CODE_FAULT});
    state_oh = 8'h10;
    // Input and charger flags one at a time, then all together
    for (int b = 0; b < 6; b++) begin
      flags = 6'(1 << b);
      settle();
      rd(8'h02, 8'(1 << b));
    end
    flags = 6'h3f;
    settle();
    rd(8'h02, 8'h3f);
    // Writes of all ones change nothing, and bits 7:6 stay clear
    for (int i = 0; i < 3; i++) begin
      wr(8'(i), 8'hff);
    end
    rd(8'h00, REV);
    rd(8'h01, {2'h0, csr_pkg::ZONE_HOT, csr_pkg::CHG_CODE_FAST_CV});
    rd(8'h02, 8'h3f);
    rd(8'h10, 8'h00);
    // Second reset in mid-run clears the read port, then status returns
    @(negedge clk);
    rst = 1'h1;
    @(negedge clk);
    check(rdata, 8'h00);
    check({7'h00, rd_valid}, 8'h00);
    rst = 1'h0;
    settle();
    rd(8'h02, 8'h3f);
    rd(8'h00, REV);
    report_and_stop();
  end
endmodule
